// File: logic/mas_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module mas_status_regs
    import mas_pkg::*;
#(
    parameter int REMAIN_W = MAS_REMAIN_W
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rstn,
    // Host read port
    input  wire logic                    rd_strobe,
    input  wire logic [2:0]              rd_sel,
    output logic [31:0]                  rd_data_r,
    output logic                         rd_valid_r,
    // Axis state
    input  wire logic [3:0]              operation_state_code,
    input  wire logic                    direction_flag,
    input  wire logic                    ext_start_input,
    input  wire logic                    ext_stop_input,
    input  wire logic                    emergency_stop_input,
    input  wire logic                    target_reached_input,
    input  wire logic                    deviation_clear_output,
    input  wire logic                    encoder_index_input,
    input  wire logic                    plus_jog_input,
    input  wire logic                    minus_jog_input,
    input  wire logic                    counter_clear_input,
    input  wire logic                    latch_input,
    input  wire logic                    slowdown_input,
    input  wire logic                    in_position_input,
    // Error event pulses
    input  wire logic [4:0]              err_cmp_halt,
    input  wire logic [4:0]              err_ext_halt,
    input  wire logic                    err_slowdown_halt,
    input  wire logic                    err_bad_data,
    input  wire logic                    err_interp_stop,
    input  wire logic                    err_pulser_overflow,
    input  wire logic                    err_inpos_overrange,
    input  wire logic                    err_encoder_input,
    input  wire logic                    err_pulser_input,
    // Event pulses
    input  wire logic [7:0]              evt_motion,
    input  wire logic [4:0]              evt_cmp_met,
    input  wire logic [2:0]              evt_counter,
    input  wire logic [3:0]              evt_input,
    // Pulse engine
    input  wire logic                    op_start,
    input  wire logic                    pulse_out,
    input  wire logic [REMAIN_W-1:0]     target_position_setting,
    input  wire logic                    pulse_gen_active,
    input  wire logic [MAS_SPEED_W-1:0]  present_speed_field,
    input  wire logic [MAS_INDEX_W-1:0]  index_counter_field,
    input  wire logic [MAS_IDLE_W-1:0]   idling_count_field,
    input  wire logic [MAS_RAMP_W-1:0]   ramp_down_point,
    // Shared interpolation state
    input  wire logic [MAS_AXES-1:0]     interp_lin1_member,
    input  wire logic [MAS_AXES-1:0]     interp_lin2_member,
    input  wire logic [MAS_AXES-1:0]     interp_circ_member,
    input  wire logic [MAS_AXES-1:0]     interp_const_speed,
    input  wire logic                    lin1_active,
    input  wire logic                    lin2_active,
    input  wire logic                    circ_cw_active,
    input  wire logic                    circ_ccw_active,
    input  wire logic [1:0]              present_quadrant,
    input  wire logic [1:0]              ending_quadrant
);

    typedef struct packed {
        logic [MAS_ERR_W-1:0] err_cause;
        logic [MAS_EVT_W-1:0] evt_cause;
        logic [REMAIN_W-1:0]  remain;
        logic [31:0]          rd_data;
        logic                 rd_valid;
    } mas_state_type;

    mas_state_type st_r;
    mas_state_type st_nxt;

    logic [31:0]                 ext_word;
    logic [31:0]                 err_word;
    logic [31:0]                 evt_word;
    logic [31:0]                 remain_word;
    logic [31:0]                 speed_word;
    logic [31:0]                 ramp_word;
    logic [31:0]                 interp_word;
    logic [31:0]                 sel_word;
    logic [MAS_ERR_W-1:0]        err_set;
    logic [MAS_EVT_W-1:0]        evt_set;
    logic [REMAIN_W-1:0]         target_neg;
    logic [REMAIN_W-1:0]         target_abs;
    logic [REMAIN_W-1:0]         remain_step;
    logic [MAS_EXT_PIN_W-1:0]    pin_levels;
    wire logic [4*MAS_AXES-1:0]  member_bits;
    logic                        err_read_hit;
    logic                        evt_read_hit;
    logic                        remain_empty;
    logic                        remain_load;
    logic                        remain_dec;

    // Pin monitor in bit order 5..16
    always_comb begin
        pin_levels = {in_position_input,       // bit 16
                      slowdown_input,          // bit 15
                      latch_input,             // bit 14
                      counter_clear_input,     // bit 13
                      minus_jog_input,         // bit 12
                      plus_jog_input,          // bit 11
                      encoder_index_input,     // bit 10
                      deviation_clear_output,  // bit 9
                      target_reached_input,    // bit 8
                      emergency_stop_input,    // bit 7
                      ext_stop_input,          // bit 6
                      ext_start_input};        // bit 5
    end

    // State code, direction, then pin monitor
    always_comb begin
        ext_word = MAS_RST_WORD;
        ext_word[MAS_EXT_STATE_LSB +: 4] = operation_state_code;
        ext_word[MAS_EXT_DIR_BIT] = direction_flag;
        ext_word[MAS_EXT_PIN_LSB +: MAS_EXT_PIN_W] = pin_levels;
    end

    // A clearing read is one taken on the cause word's select
    always_comb begin
        err_read_hit = rd_strobe && (rd_sel == MAS_SEL_ERR_CAUSE);
        evt_read_hit = rd_strobe && (rd_sel == MAS_SEL_EVT_CAUSE);
    end

    // Error pulses into their cause bit positions
    always_comb begin
        err_set = MAS_RST_ERR;
        // Comparator halts, soft limits first
        err_set[MAS_ERR_CMP_LSB + 0] = err_cmp_halt[0];
        err_set[MAS_ERR_CMP_LSB + 1] = err_cmp_halt[1];
        err_set[MAS_ERR_CMP_LSB + 2] = err_cmp_halt[2];
        err_set[MAS_ERR_CMP_LSB + 3] = err_cmp_halt[3];
        err_set[MAS_ERR_CMP_LSB + 4] = err_cmp_halt[4];
        // End limits, alarm and stop inputs
        err_set[MAS_ERR_LIM_LSB + 0] = err_ext_halt[0];
        err_set[MAS_ERR_LIM_LSB + 1] = err_ext_halt[1];
        err_set[MAS_ERR_LIM_LSB + 2] = err_ext_halt[2];
        err_set[MAS_ERR_LIM_LSB + 3] = err_ext_halt[3];
        err_set[MAS_ERR_LIM_LSB + 4] = err_ext_halt[4];
        // Single-bit causes
        err_set[MAS_ERR_SLOW_BIT] = err_slowdown_halt;
        err_set[MAS_ERR_ZERO_BIT] = 1'b0;
        err_set[MAS_ERR_DATA_BIT] = err_bad_data;
        err_set[MAS_ERR_SYNC_BIT] = err_interp_stop;
        err_set[MAS_ERR_PBOV_BIT] = err_pulser_overflow;
        err_set[MAS_ERR_INP_BIT]  = err_inpos_overrange;
        err_set[MAS_ERR_ENC_BIT]  = err_encoder_input;
        err_set[MAS_ERR_PUL_BIT]  = err_pulser_input;
    end

    // Event pulses into their cause bit positions
    always_comb begin
        evt_set = MAS_RST_EVT;
        // Motion profile events
        evt_set[MAS_EVT_MOT_LSB + 0] = evt_motion[0];
        evt_set[MAS_EVT_MOT_LSB + 1] = evt_motion[1];
        evt_set[MAS_EVT_MOT_LSB + 2] = evt_motion[2];
        evt_set[MAS_EVT_MOT_LSB + 3] = evt_motion[3];
        evt_set[MAS_EVT_MOT_LSB + 4] = evt_motion[4];
        evt_set[MAS_EVT_MOT_LSB + 5] = evt_motion[5];
        evt_set[MAS_EVT_MOT_LSB + 6] = evt_motion[6];
        evt_set[MAS_EVT_MOT_LSB + 7] = evt_motion[7];
        // Comparator conditions met
        evt_set[MAS_EVT_CMP_LSB + 0] = evt_cmp_met[0];
        evt_set[MAS_EVT_CMP_LSB + 1] = evt_cmp_met[1];
        evt_set[MAS_EVT_CMP_LSB + 2] = evt_cmp_met[2];
        evt_set[MAS_EVT_CMP_LSB + 3] = evt_cmp_met[3];
        evt_set[MAS_EVT_CMP_LSB + 4] = evt_cmp_met[4];
        // Counter clear and latches
        evt_set[MAS_EVT_CNT_LSB + 0] = evt_counter[0];
        evt_set[MAS_EVT_CNT_LSB + 1] = evt_counter[1];
        evt_set[MAS_EVT_CNT_LSB + 2] = evt_counter[2];
        // Input events
        evt_set[MAS_EVT_IN_LSB + 0] = evt_input[0];
        evt_set[MAS_EVT_IN_LSB + 1] = evt_input[1];
        evt_set[MAS_EVT_IN_LSB + 2] = evt_input[2];
        evt_set[MAS_EVT_IN_LSB + 3] = evt_input[3];
    end

    // Magnitude of the signed target; most negative value fits unsigned
    always_comb begin
        target_neg = REMAIN_W'(~target_position_setting + 1'h1);
        if (target_position_setting[REMAIN_W-1]) begin
            target_abs = target_neg;
        end else begin
            target_abs = target_position_setting;
        end
    end

    // Count sticks at zero rather than wrapping
    always_comb begin
        remain_empty = (st_r.remain == '0);
        remain_step  = st_r.remain - 1'h1;
        remain_load  = op_start;
        remain_dec   = pulse_out && !remain_empty;
    end

    // Sticky error causes
    always_comb begin
        err_word = MAS_RST_WORD;
        err_word[MAS_ERR_W-1:0] = st_r.err_cause;
        err_word[MAS_ERR_ZERO_BIT] = 1'h0;
    end

    // Sticky event causes, upper bits zero
    always_comb begin
        evt_word = MAS_RST_WORD;
        evt_word[MAS_EVT_W-1:0] = st_r.evt_cause;
    end

    // Remaining count, top bits zero
    always_comb begin
        remain_word = MAS_RST_WORD;
        remain_word[REMAIN_W-1:0] = st_r.remain;
    end

    // Speed field reads zero once pulse generation stops
    always_comb begin
        speed_word = MAS_RST_WORD;
        if (pulse_gen_active) begin
            speed_word[MAS_SPEED_W-1:0] = present_speed_field;
        end
        speed_word[MAS_SPD_INDEX_LSB +: MAS_INDEX_W] = index_counter_field;
        speed_word[MAS_SPD_IDLE_LSB +: MAS_IDLE_W] = idling_count_field;
    end

    // Ramp-down point, top byte zero
    always_comb begin
        ramp_word = MAS_RST_WORD;
        ramp_word[MAS_RAMP_W-1:0] = ramp_down_point;
    end

    // One set of membership bits per axis, X first
    for (genvar ax = 0; ax < MAS_AXES; ax++) begin : g_axis
        assign member_bits[MAS_IPS_LIN1_LSB + ax] = interp_lin1_member[ax];
        assign member_bits[MAS_IPS_LIN2_LSB + ax] = interp_lin2_member[ax];
        assign member_bits[MAS_IPS_CIRC_LSB + ax] = interp_circ_member[ax];
        assign member_bits[MAS_IPS_CSPD_LSB + ax] = interp_const_speed[ax];
    end

    // Shared word built only from common inputs, so every axis reads the same
    always_comb begin
        interp_word = MAS_RST_WORD;
        interp_word[4*MAS_AXES-1:0] = member_bits;
        interp_word[MAS_IPS_RUN_LSB + 0] = lin1_active;
        interp_word[MAS_IPS_RUN_LSB + 1] = lin2_active;
        interp_word[MAS_IPS_RUN_LSB + 2] = circ_cw_active;
        interp_word[MAS_IPS_RUN_LSB + 3] = circ_ccw_active;
        interp_word[MAS_IPS_PQUAD_LSB +: 2] = present_quadrant;
        interp_word[MAS_IPS_EQUAD_LSB +: 2] = ending_quadrant;
    end

    // Word picked by the select, unmapped code reads zero
    always_comb begin
        unique case (rd_sel)
            MAS_SEL_EXT_STATUS: sel_word = ext_word;
            MAS_SEL_ERR_CAUSE:  sel_word = err_word;
            MAS_SEL_EVT_CAUSE:  sel_word = evt_word;
            MAS_SEL_REMAIN:     sel_word = remain_word;
            MAS_SEL_SPEED:      sel_word = speed_word;
            MAS_SEL_RAMP_DOWN:  sel_word = ramp_word;
            MAS_SEL_INTERP:     sel_word = interp_word;
            default:            sel_word = MAS_RST_WORD;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        // Answer registered one cycle after the strobe
        st_nxt.rd_valid = rd_strobe;
        if (rd_strobe) begin
            st_nxt.rd_data = sel_word;
        end
        // Clear on read, new causes in the same cycle survive
        if (err_read_hit) begin
            st_nxt.err_cause = err_set;
        end else begin
            st_nxt.err_cause = st_r.err_cause | err_set;
        end
        if (evt_read_hit) begin
            st_nxt.evt_cause = evt_set;
        end else begin
            st_nxt.evt_cause = st_r.evt_cause | evt_set;
        end
        // Load wins over a pulse in the start cycle
        if (remain_load) begin
            st_nxt.remain = target_abs;
        end else if (remain_dec) begin
            st_nxt.remain = remain_step;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r.err_cause <= MAS_RST_ERR;
            st_r.evt_cause <= MAS_RST_EVT;
            st_r.remain    <= '0;
            st_r.rd_data   <= MAS_RST_WORD;
            st_r.rd_valid  <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_r  = st_r.rd_data;
    assign rd_valid_r = st_r.rd_valid;

endmodule : mas_status_regs
`default_nettype wire

// File: logic/mas_pkg.sv
`default_nettype none
package mas_pkg;
    // Read select codes
    localparam logic [2:0] MAS_SEL_EXT_STATUS  = 3'h0;
    localparam logic [2:0] MAS_SEL_ERR_CAUSE   = 3'h1;
    localparam logic [2:0] MAS_SEL_EVT_CAUSE   = 3'h2;
    localparam logic [2:0] MAS_SEL_REMAIN      = 3'h3;
    localparam logic [2:0] MAS_SEL_SPEED       = 3'h4;
    localparam logic [2:0] MAS_SEL_RAMP_DOWN   = 3'h5;
    localparam logic [2:0] MAS_SEL_INTERP      = 3'h6;

    // Extended status field positions
    localparam int MAS_EXT_STATE_LSB = 0;
    localparam int MAS_EXT_DIR_BIT   = 4;
    localparam int MAS_EXT_PIN_LSB   = 5;
    localparam int MAS_EXT_PIN_W     = 12;

    // Cause word widths and the fixed-zero error bit
    localparam int MAS_ERR_W        = 18;
    localparam int MAS_ERR_ZERO_BIT = 11;
    localparam int MAS_EVT_W        = 20;

    // Error cause field positions
    localparam int MAS_ERR_CMP_LSB  = 0;
    localparam int MAS_ERR_LIM_LSB  = 5;
    localparam int MAS_ERR_SLOW_BIT = 10;
    localparam int MAS_ERR_DATA_BIT = 12;
    localparam int MAS_ERR_SYNC_BIT = 13;
    localparam int MAS_ERR_PBOV_BIT = 14;
    localparam int MAS_ERR_INP_BIT  = 15;
    localparam int MAS_ERR_ENC_BIT  = 16;
    localparam int MAS_ERR_PUL_BIT  = 17;

    // Event cause field positions
    localparam int MAS_EVT_MOT_LSB = 0;
    localparam int MAS_EVT_CMP_LSB = 8;
    localparam int MAS_EVT_CNT_LSB = 13;
    localparam int MAS_EVT_IN_LSB  = 16;

    // Counter and field widths
    localparam int MAS_REMAIN_W = 28;
    localparam int MAS_SPEED_W  = 16;
    localparam int MAS_INDEX_W  = 4;
    localparam int MAS_IDLE_W   = 3;
    localparam int MAS_RAMP_W   = 24;
    localparam int MAS_AXES     = 4;

    // Speed word field positions
    localparam int MAS_SPD_INDEX_LSB = 16;
    localparam int MAS_SPD_IDLE_LSB  = 20;

    // Interpolation status field positions
    localparam int MAS_IPS_LIN1_LSB  = 0;
    localparam int MAS_IPS_LIN2_LSB  = 4;
    localparam int MAS_IPS_CIRC_LSB  = 8;
    localparam int MAS_IPS_CSPD_LSB  = 12;
    localparam int MAS_IPS_RUN_LSB   = 16;
    localparam int MAS_IPS_PQUAD_LSB = 20;
    localparam int MAS_IPS_EQUAD_LSB = 22;

    // Reset values
    localparam logic [31:0]           MAS_RST_WORD   = 32'h0000_0000;
    localparam logic [MAS_ERR_W-1:0]  MAS_RST_ERR    = 18'h0_0000;
    localparam logic [MAS_EVT_W-1:0]  MAS_RST_EVT    = 20'h0_0000;
    localparam logic [MAS_REMAIN_W-1:0] MAS_RST_REMAIN = 28'h000_0000;
endpackage : mas_pkg
`default_nettype wire

// File: verif/mas_status_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mas_status_regs_chk
    import mas_pkg::*;
(
    input wire logic                   sys_clk,
    input wire logic                   rstn,
    input wire logic                   rd_strobe,
    input wire logic [2:0]             rd_sel,
    input wire logic [31:0]            rd_data_r,
    input wire logic                   rd_valid_r,
    input wire logic                   pulse_gen_active,
    input wire logic [MAS_SPEED_W-1:0] present_speed_field,
    input wire logic [MAS_INDEX_W-1:0] index_counter_field,
    input wire logic [MAS_IDLE_W-1:0]  idling_count_field,
    input wire logic [MAS_RAMP_W-1:0]  ramp_down_point,
    input wire logic [7:0]             evt_motion
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    read_answer_a: assert property (rd_strobe |=> rd_valid_r) else $error("read answer missing");
    no_spurious_a: assert property (!rd_strobe |=> !rd_valid_r) else $error("answer without read");
    unmapped_zero_a: assert property (rd_strobe && rd_sel == 3'h7 |=> rd_data_r == 32'h0)
        else $error("unmapped read not zero");
    err_fixed_a: assert property (rd_strobe && rd_sel == MAS_SEL_ERR_CAUSE |=>
        rd_data_r[31:18] == 14'h0 && !rd_data_r[MAS_ERR_ZERO_BIT]) else $error("error word fixed bits set");
    evt_fixed_a: assert property (rd_strobe && rd_sel == MAS_SEL_EVT_CAUSE |=>
        rd_data_r[31:20] == 12'h0) else $error("event word high bits set");
    remain_top_a: assert property (rd_strobe && rd_sel == MAS_SEL_REMAIN |=>
        rd_data_r[31:28] == 4'h0) else $error("remaining count top bits set");
    speed_word_a: assert property (rd_strobe && rd_sel == MAS_SEL_SPEED |=>
        rd_data_r == {9'h0, $past(idling_count_field), $past(index_counter_field),
        $past(pulse_gen_active) ? $past(present_speed_field) : 16'h0}) else $error("speed word wrong");
    ramp_word_a: assert property (rd_strobe && rd_sel == MAS_SEL_RAMP_DOWN |=>
        rd_data_r == {8'h0, $past(ramp_down_point)}) else $error("ramp-down word wrong");
    set_wins_a: assert property (rd_strobe && rd_sel == MAS_SEL_EVT_CAUSE && evt_motion[0] ##1
        rd_strobe && rd_sel == MAS_SEL_EVT_CAUSE |=> rd_data_r[0]) else $error("event set lost");
endmodule : mas_status_regs_chk
bind mas_status_regs mas_status_regs_chk i_chk (.*);
`default_nettype wire

// File: verif/mas_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mas_host_model (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       want,
    input  wire logic [2:0] want_sel,
    output logic            rd_strobe,
    output logic [2:0]      rd_sel
);
    // One-cycle read strobe per requested cycle, select held with it
    initial begin
        rd_strobe = 1'b0;
        rd_sel    = 3'h0;
    end
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_strobe <= 1'b0;
        end else begin
            rd_strobe <= want;
            rd_sel    <= want_sel;
        end
    end
endmodule : mas_host_model
`default_nettype wire

// File: verif/mas_status_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module mas_status_regs_test
    import mas_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic rd_strobe, rd_valid_r, want, valid_q, direction_flag, ext_start_input, ext_stop_input;
    logic emergency_stop_input, target_reached_input, deviation_clear_output, encoder_index_input;
    logic plus_jog_input, minus_jog_input, counter_clear_input, latch_input, slowdown_input;
    logic in_position_input, err_slowdown_halt, err_bad_data, err_interp_stop, err_pulser_overflow;
    logic err_inpos_overrange, err_encoder_input, err_pulser_input, op_start, pulse_out;
    logic pulse_gen_active, lin1_active, lin2_active, circ_cw_active, circ_ccw_active;
    logic [1:0] present_quadrant, ending_quadrant;
    logic [2:0] rd_sel, want_sel, evt_counter, es;
    logic [3:0] operation_state_code, evt_input, interp_lin1_member, interp_lin2_member;
    logic [3:0] interp_circ_member, interp_const_speed, index_counter_field;
    logic [4:0] err_cmp_halt, err_ext_halt, evt_cmp_met;
    logic [7:0] evt_motion;
    logic [MAS_IDLE_W-1:0] idling_count_field;
    logic [15:0] present_speed_field;
    logic [17:0] err_m;
    logic [19:0] evt_m;
    logic [23:0] ramp_down_point;
    logic [27:0] target_position_setting, rem_m;
    logic [31:0] rd_data_r, eq, a, b, c, r = 32'h1f;
    int cyc = 0;
    int errors = 0;
    int checks_done = 0;
    mas_status_regs i_dut (.*);
    mas_host_model i_host (.*);
    always #12.5 sys_clk = ~sys_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] word_of(input logic [2:0] s);
        case (s)
            MAS_SEL_EXT_STATUS: return {15'h0, in_position_input, slowdown_input, latch_input, counter_clear_input,
                minus_jog_input, plus_jog_input, encoder_index_input, deviation_clear_output, target_reached_input,
                emergency_stop_input, ext_stop_input, ext_start_input, direction_flag, operation_state_code};
            MAS_SEL_ERR_CAUSE: return {14'h0, err_m};
            MAS_SEL_EVT_CAUSE: return {12'h0, evt_m};
            MAS_SEL_REMAIN: return {4'h0, rem_m};
            MAS_SEL_SPEED: return {9'h0, idling_count_field, index_counter_field,
                pulse_gen_active ? present_speed_field : 16'h0};
            MAS_SEL_RAMP_DOWN: return {8'h0, ramp_down_point};
            MAS_SEL_INTERP: return {8'h0, ending_quadrant, present_quadrant, circ_ccw_active, circ_cw_active,
                lin2_active, lin1_active, interp_const_speed, interp_circ_member, interp_lin2_member,
                interp_lin1_member};
            default: return 32'h0;
        endcase
    endfunction : word_of
    task automatic chk(input string nm, input logic [31:0] e, g, m);
        checks_done++;
        if ((g & m) !== (e & m)) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e & m, g & m);
        end
    endtask : chk
    // Sparse causes, with bursts of all causes during reads of one cause word
    task automatic drive(input logic [31:0] x, y, z, input logic burst, hw, input logic [2:0] hs);
        {operation_state_code, direction_flag, ext_start_input, ext_stop_input, emergency_stop_input,
            target_reached_input, deviation_clear_output, encoder_index_input, plus_jog_input, minus_jog_input,
            counter_clear_input, latch_input, slowdown_input, in_position_input} <= x[16:0];
        {err_cmp_halt, err_ext_halt, err_slowdown_halt, err_bad_data, err_interp_stop, err_pulser_overflow,
            err_inpos_overrange, err_encoder_input, err_pulser_input} <= burst ? 17'h1ffff : x[16:0] & y[16:0] & z[16:0];
        {evt_motion, evt_cmp_met, evt_counter, evt_input} <= burst ? 20'hfffff : ~x[19:0] & y[19:0] & z[19:0];
        op_start <= x[31:28] == 4'h0;
        pulse_out <= y[0] | y[1];
        target_position_setting <= x[20] ? z[27:0] : {{25{z[0]}}, z[3:1]};
        {pulse_gen_active, present_speed_field, index_counter_field, idling_count_field} <= {y[31], z[22:0]};
        ramp_down_point <= {x[7:0], y[15:0]};
        {interp_lin1_member, interp_lin2_member, interp_circ_member, interp_const_speed} <= y[15:0];
        {lin1_active, lin2_active, circ_cw_active, circ_ccw_active} <= z[31:28];
        {present_quadrant, ending_quadrant} <= x[24:21];
        want <= hw | x[29];
        want_sel <= hw ? hs : z[30:28];
    endtask : drive
    task automatic report_and_stop();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge sys_clk) begin
        if (!rstn) begin
            {err_m, evt_m, rem_m, valid_q} = '0;
        end else begin
            chk("rd_valid_r", {31'h0, valid_q}, {31'h0, rd_valid_r}, 32'h1);
            if (valid_q) case (es)
                MAS_SEL_EXT_STATUS: chk("ext_status", eq, rd_data_r, '1);
                MAS_SEL_ERR_CAUSE: begin
                    chk("err_low", eq, rd_data_r, 32'h3ff);
                    chk("err_high", eq, rd_data_r, 32'hfffffc00);
                end
                MAS_SEL_EVT_CAUSE: begin
                    chk("evt_low", eq, rd_data_r, 32'hfff);
                    chk("evt_high", eq, rd_data_r, 32'hfffff000);
                end
                MAS_SEL_REMAIN: chk("remaining", eq, rd_data_r, '1);
                MAS_SEL_SPEED: chk("speed", eq, rd_data_r, '1);
                MAS_SEL_INTERP: chk("interp", eq, rd_data_r, '1);
                default: chk("other_word", eq, rd_data_r, '1);
            endcase
            valid_q = rd_strobe;
            es = rd_sel;
            if (rd_strobe) eq = word_of(rd_sel);
            err_m = (rd_strobe && rd_sel == MAS_SEL_ERR_CAUSE ? 18'h0 : err_m) | {err_pulser_input,
                err_encoder_input, err_inpos_overrange, err_pulser_overflow, err_interp_stop, err_bad_data, 1'b0,
                err_slowdown_halt, err_ext_halt, err_cmp_halt};
            evt_m = (rd_strobe && rd_sel == MAS_SEL_EVT_CAUSE ? 20'h0 : evt_m)
                | {evt_input, evt_counter, evt_cmp_met, evt_motion};
            if (op_start) rem_m = target_position_setting[27] ? -target_position_setting : target_position_setting;
            else if (pulse_out && rem_m != 28'h0) rem_m = rem_m - 28'h1;
        end
        a = lfsr(r);
        b = lfsr(a);
        c = lfsr(b);
        r = c;
        cyc++;
        drive(a, b, c, cyc % 500 < 2, cyc % 500 < 4, cyc % 1000 < 500 ? MAS_SEL_ERR_CAUSE : MAS_SEL_EVT_CAUSE);
    end
    initial begin
        drive(32'h0, 32'h0, 32'h0, 1'b0, 1'b0, 3'h0);
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4000) @(posedge sys_clk);
        report_and_stop();
    end
endmodule : mas_status_regs_test
`default_nettype wire
